// file: plh_ctrl_model.sv
// external launch controller and programming engine stand-in
`timescale 1ns/1ps

module plh_ctrl_model (
  input  wire logic aclk,
  input  wire logic idle_w,
  input  wire logic pass_w,
  input  wire logic fail_w,
  input  wire logic prog_start,
  output logic      start_n_in,
  output logic      prog_done,
  output logic      prog_ok
);
  // stands in for the polling controller's 100 ms settle; any wait past the
  // launch latency behaves the same, and a short one keeps the run brief
  localparam int POLL_WAIT = 16;

  logic ok_cfg;
  int   dly_cfg;
  int   cnt;

  initial
  begin
    start_n_in = 1'b1;
    prog_done  = 1'b0;
    prog_ok    = 1'b0;
    ok_cfg     = 1'b1;
    dly_cfg    = 4;
    cnt        = 0;
  end

  // ==========================================================================
  // engine: prog_ok toggles when not qualified, so nothing leans on a stale level
  always @(posedge aclk)
  begin
    prog_done <= 1'b0;
    prog_ok   <= ~prog_ok;
    if (prog_start) cnt <= dly_cfg;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      cnt       <= 0;
      prog_done <= 1'b1;
      prog_ok   <= ok_cfg;
    end
  end

  // ==========================================================================
  // controller side
  task automatic pulse(input int len);
    @(posedge aclk) start_n_in <= 1'b0;
    repeat (len) @(posedge aclk);
    start_n_in <= 1'b1;
  endtask

  task automatic launch(input int len, output logic ok_seen, output logic err_seen);
    while (idle_w) @(posedge aclk);
    pulse(len);
    while (!idle_w) @(posedge aclk);
    while (idle_w) @(posedge aclk);
    ok_seen  = !pass_w;
    err_seen = !fail_w;
  endtask

  // polling controller: no edge detection on idle, a fixed settle instead
  task automatic launch_polled(input int len, output logic ok_seen, output logic err_seen);
    while (idle_w) @(posedge aclk);
    pulse(len);
    repeat (POLL_WAIT) @(posedge aclk);
    while (idle_w) @(posedge aclk);
    ok_seen  = !pass_w;
    err_seen = !fail_w;
  endtask
endmodule // plh_ctrl_model

// file: plh_launch_port.sv
// launch and status handshake of the programming control port
`timescale 1ns/1ps
`include "plh_regs.svh"

module plh_launch_port (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire plh_pkg::plh_axi_req_type axi_req,
  output plh_pkg::plh_axi_rsp_type      axi_rsp,
  input  wire logic                     start_n_in,
  input  wire logic                     sense_n_in,
  input  wire logic                     port_io_supply,
  output plh_pkg::plh_pins_type         pins_out,
  output plh_pkg::plh_pins_type         pins_oe,
  output logic                          prog_start,
  input  wire logic                     prog_done,
  input  wire logic                     prog_ok,
  input  wire logic                     nv_saved_value,
  output logic                          nv_commit_req,
  output logic                          nv_commit_data
);

  // ========================================================================
  // declarations
  plh_pkg::plh_state_type state_reg;
  plh_pkg::plh_pins_type  pins_reg;
  plh_pkg::plh_pins_type  oe_reg;
  logic       start_s1_reg;
  logic       start_s2_reg;
  logic       start_s3_reg;
  logic       pend_reg;
  logic       active_reg;
  logic       prog_start_reg;
  logic       awready_reg;
  logic       wready_reg;
  logic       bvalid_reg;
  logic [1:0] bresp_reg;
  logic       arready_reg;
  logic       rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic       wstrb0_reg;
  logic       aw_have_reg;
  logic       w_have_reg;
  logic       enable;
  logic       nv_wr_en;
  logic       fall_edge;
  logic       launch_ok;

  function automatic logic reg_hit(input logic [7:0] addr);
    reg_hit = (addr == `PLH_CTRL_OFFSET) || (addr == `PLH_STATUS_OFFSET)
           || (addr == `PLH_RESULT_OFFSET);
  endfunction

  // ========================================================================
  // launch edge capture; s1 feeds s2 only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_s1_reg <= 1'h1;
      start_s2_reg <= 1'h1;
      start_s3_reg <= 1'h1;
    end
    else
    begin
      start_s1_reg <= start_n_in;
      start_s2_reg <= start_s1_reg;
      start_s3_reg <= start_s2_reg;
    end
  end

  assign fall_edge = start_s3_reg && !start_s2_reg;

  // pending edge is held until the sequencer takes it, so a late look still sees it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pend_reg <= 1'h0;
    else if (fall_edge && state_reg == plh_pkg::PLH_IDLE)
      pend_reg <= 1'h1;
    else if (state_reg != plh_pkg::PLH_IDLE)
      pend_reg <= 1'h0;
  end

  // ========================================================================
  // port activity
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_reg <= 1'h0;
    else
      active_reg <= port_io_supply && !sense_n_in;
  end

  // a pending edge with no permission or inactive port is deferred, not dropped; it launches once both are present
  assign launch_ok = pend_reg && enable && active_reg;

  // ========================================================================
  // launch sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= plh_pkg::PLH_IDLE;
    else
    begin
      unique case (state_reg)
        plh_pkg::PLH_IDLE:
          if (launch_ok)
            state_reg <= plh_pkg::PLH_CLEAR;
        plh_pkg::PLH_CLEAR:
          state_reg <= plh_pkg::PLH_BUSY;
        plh_pkg::PLH_BUSY:
          if (prog_done)
            state_reg <= plh_pkg::PLH_REPORT;
        plh_pkg::PLH_REPORT:
          state_reg <= plh_pkg::PLH_RELEASE;
        plh_pkg::PLH_RELEASE:
          state_reg <= plh_pkg::PLH_IDLE;
      endcase
    end
  end

  // ========================================================================
  // pin levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pins_reg <= '{pass_n: 1'h1, fail_n: 1'h1, idle_n: 1'h0};
    else
    begin
      unique case (state_reg)
        plh_pkg::PLH_IDLE:
          if (launch_ok)
          begin
            pins_reg.pass_n <= 1'h1;
            pins_reg.fail_n <= 1'h1;
          end
        plh_pkg::PLH_CLEAR:
          pins_reg.idle_n <= 1'h1;
        plh_pkg::PLH_BUSY:
          if (prog_done)
          begin
            pins_reg.pass_n <= !prog_ok;
            pins_reg.fail_n <= prog_ok;
          end
        plh_pkg::PLH_REPORT:
          pins_reg.idle_n <= 1'h0;
        plh_pkg::PLH_RELEASE:
          pins_reg.idle_n <= 1'h0;
      endcase
    end
  end

  // outputs float until the port has its own supply
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      oe_reg <= '{pass_n: 1'h0, fail_n: 1'h0, idle_n: 1'h0};
    else
      oe_reg <= '{pass_n: port_io_supply, fail_n: port_io_supply,
                  idle_n: port_io_supply};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prog_start_reg <= 1'h0;
    else
      prog_start_reg <= (state_reg == plh_pkg::PLH_CLEAR);
  end

  // ========================================================================
  // axi4-lite write channel; address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'h0;
      w_have_reg  <= 1'h0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb0_reg  <= 1'h0;
      bvalid_reg  <= 1'h0;
      bresp_reg   <= `PLH_RESP_OKAY;
    end
    else
    begin
      if (axi_req.awvalid && awready_reg)
      begin
        aw_have_reg <= 1'h1;
        awaddr_reg  <= axi_req.awaddr;
      end
      if (axi_req.wvalid && wready_reg)
      begin
        w_have_reg <= 1'h1;
        wdata_reg  <= axi_req.wdata;
        wstrb0_reg <= axi_req.wstrb[0];
      end
      if (aw_have_reg && w_have_reg && !bvalid_reg)
      begin
        bvalid_reg  <= 1'h1;
        bresp_reg   <= reg_hit(awaddr_reg) ? `PLH_RESP_OKAY : `PLH_RESP_SLVERR;
        aw_have_reg <= 1'h0;
        w_have_reg  <= 1'h0;
      end
      else if (bvalid_reg && axi_req.bready)
        bvalid_reg <= 1'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'h0;
      wready_reg  <= 1'h0;
    end
    else
    begin
      awready_reg <= !aw_have_reg && !(axi_req.awvalid && awready_reg) && !bvalid_reg;
      wready_reg  <= !w_have_reg && !(axi_req.wvalid && wready_reg) && !bvalid_reg;
    end
  end

  // only the control word is writable; status and result writes are ignored
  assign nv_wr_en = aw_have_reg && w_have_reg && !bvalid_reg && wstrb0_reg
                 && (awaddr_reg == `PLH_CTRL_OFFSET);

  plh_nv_store u_nv_store (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .nv_saved_value (nv_saved_value),
    .wr_en          (nv_wr_en),
    .wr_data        (wdata_reg[`PLH_CTRL_ENABLE_BIT]),
    .enable         (enable),
    .commit_req     (nv_commit_req),
    .commit_data    (nv_commit_data)
  );

  // ========================================================================
  // axi4-lite read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'h0;
      rvalid_reg  <= 1'h0;
      rdata_reg   <= `PLH_READ_ZERO;
      rresp_reg   <= `PLH_RESP_OKAY;
    end
    else if (arready_reg && axi_req.arvalid)
    begin
      arready_reg <= 1'h0;
      rvalid_reg  <= 1'h1;
      rresp_reg   <= reg_hit(axi_req.araddr) ? `PLH_RESP_OKAY : `PLH_RESP_SLVERR;
      rdata_reg   <= `PLH_READ_ZERO;
      unique case (axi_req.araddr)
        `PLH_CTRL_OFFSET:
          rdata_reg[`PLH_CTRL_ENABLE_BIT] <= enable;
        `PLH_STATUS_OFFSET:
        begin
          rdata_reg[`PLH_STAT_ACTIVE_BIT] <= active_reg;
          rdata_reg[`PLH_STAT_BUSY_BIT]   <= pins_reg.idle_n;
          rdata_reg[`PLH_STAT_PASS_BIT]   <= !pins_reg.pass_n;
          rdata_reg[`PLH_STAT_FAIL_BIT]   <= !pins_reg.fail_n;
          rdata_reg[`PLH_STAT_PEND_BIT]   <= pend_reg;
          rdata_reg[`PLH_STAT_SUPPLY_BIT] <= port_io_supply;
          rdata_reg[`PLH_STAT_ENABLE_BIT] <= enable;
        end
        `PLH_RESULT_OFFSET:
        begin
          rdata_reg[`PLH_RES_PASS_BIT] <= !pins_reg.pass_n;
          rdata_reg[`PLH_RES_FAIL_BIT] <= !pins_reg.fail_n;
        end
        default:
          rdata_reg <= `PLH_READ_ZERO;
      endcase
    end
    else if (rvalid_reg && axi_req.rready)
    begin
      rvalid_reg  <= 1'h0;
      arready_reg <= 1'h1;
    end
    else if (!rvalid_reg)
      arready_reg <= 1'h1;
  end

  // ========================================================================
  // outputs, all from flops
  assign axi_rsp = '{awready: awready_reg, wready: wready_reg, bvalid: bvalid_reg,
                     bresp: bresp_reg, arready: arready_reg, rvalid: rvalid_reg,
                     rdata: rdata_reg, rresp: rresp_reg};
  assign pins_out   = pins_reg;
  assign pins_oe    = oe_reg;
  assign prog_start = prog_start_reg;

endmodule // plh_launch_port

// file: plh_launch_port_properties.sv
// concurrent checks on the ports of the launch handshake block
`timescale 1ns/1ps

module plh_launch_port_checker (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire plh_pkg::plh_axi_req_type axi_req,
  input wire plh_pkg::plh_axi_rsp_type axi_rsp,
  input wire logic                     port_io_supply,
  input wire plh_pkg::plh_pins_type    pins_out,
  input wire plh_pkg::plh_pins_type    pins_oe,
  input wire logic                     prog_start,
  input wire logic                     prog_done,
  input wire logic                     prog_ok
);
  // ==========================================================================
  // handshake order and results
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_idle_a: assert property ($rose(aresetn) |-> pins_out == 3'h6)
    else $error("pins wrong after reset");
  clear_then_busy_a: assert property ($rose(pins_out.idle_n) |-> $past(pins_out.pass_n)
    && $past(pins_out.fail_n) && pins_out.pass_n && pins_out.fail_n) else $error("busy before clear");
  busy_then_start_a: assert property ($rose(pins_out.idle_n) |-> prog_start ##1 !prog_start)
    else $error("start pulse misplaced");
  result_before_idle_a: assert property ($fell(pins_out.idle_n) |-> pins_out.pass_n != pins_out.fail_n)
    else $error("idle without result");
  done_to_result_a: assert property (prog_done && pins_out == 3'h7 |=>
    pins_out.pass_n == !$past(prog_ok) && pins_out.fail_n == $past(prog_ok) ##1 !pins_out.idle_n)
    else $error("result not reported");
  oe_supply_a: assert property ($past(aresetn) |-> pins_oe == {3{$past(port_io_supply)}})
    else $error("enable does not follow supply");
  never_both_low_a: assert property (pins_out.pass_n || pins_out.fail_n)
    else $error("pass and fail both low");
  write_resp_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |=> ##1 axi_rsp.bvalid) else $error("write answer late");
  read_resp_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer late");

  cover property ($fell(pins_out.idle_n) && !pins_out.pass_n);
  cover property ($fell(pins_out.idle_n) && !pins_out.fail_n);
  cover property (axi_rsp.bvalid && axi_rsp.bresp == 2'h2);
endmodule // plh_launch_port_checker

bind plh_launch_port plh_launch_port_checker i_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .port_io_supply(port_io_supply), .pins_out(pins_out),
  .pins_oe(pins_oe), .prog_start(prog_start), .prog_done(prog_done), .prog_ok(prog_ok));

// file: plh_launch_port_tb.sv
// self-checking bench of the launch handshake block
`timescale 1ns/1ps
`include "plh_regs.svh"

module plh_launch_port_tb;
  logic                     aclk = 1'b0;
  logic                     aresetn = 1'b0;
  logic                     sense_n_in = 1'b0;
  logic                     port_io_supply = 1'b1;
  logic                     nv_saved_value = 1'b1;
  plh_pkg::plh_axi_req_type req;
  plh_pkg::plh_axi_rsp_type rsp;
  plh_pkg::plh_pins_type    pins_out;
  plh_pkg::plh_pins_type    pins_oe;
  logic                     start_n_in, prog_start, prog_done, prog_ok;
  logic                     nv_commit_req, nv_commit_data, last_commit;
  int                       n_fail = 0, checked = 0, n_start = 0, n_commit = 0;
  int                       seed = 32'h97CB41AF;
  // undriven pins float up through the pull-ups
  wire idle_w = pins_oe.idle_n ? pins_out.idle_n : 1'b1;
  wire pass_w = pins_oe.pass_n ? pins_out.pass_n : 1'b1;
  wire fail_w = pins_oe.fail_n ? pins_out.fail_n : 1'b1;

  always #5 aclk = ~aclk;

  always @(posedge aclk)
  begin
    if (prog_start) n_start <= n_start + 1;
    if (nv_commit_req) n_commit <= n_commit + 1;
    if (nv_commit_req) last_commit <= nv_commit_data;
  end

  plh_launch_port i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .start_n_in(start_n_in), .sense_n_in(sense_n_in), .port_io_supply(port_io_supply),
    .pins_out(pins_out), .pins_oe(pins_oe), .prog_start(prog_start), .prog_done(prog_done),
    .prog_ok(prog_ok), .nv_saved_value(nv_saved_value), .nv_commit_req(nv_commit_req),
    .nv_commit_data(nv_commit_data));

  plh_ctrl_model i_ctl (.aclk(aclk), .idle_w(idle_w), .pass_w(pass_w), .fail_w(fail_w),
    .prog_start(prog_start), .start_n_in(start_n_in), .prog_done(prog_done), .prog_ok(prog_ok));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) n_fail = n_fail + 1;
    if (seen !== exp) $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask

  function automatic logic [31:0] exp_status(input logic act, input logic busy, input logic en);
    exp_status = 32'h0000_0000;
    exp_status[`PLH_STAT_ACTIVE_BIT] = act;
    exp_status[`PLH_STAT_BUSY_BIT]   = busy;
    exp_status[`PLH_STAT_ENABLE_BIT] = en;
  endfunction

  task automatic report_and_stop;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge aclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      aw = aw | rsp.awready;
      w  = w | rsp.wready;
    end
    while (!rsp.bvalid) @(posedge aclk);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge aclk);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic settle(input int exp_start);
    repeat (20) @(posedge aclk);
    check(n_start, exp_start);
    check(idle_w, 1'b0);
  endtask

  // ==========================================================================
  // scenarios
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic        ok, oks, errs;
    req = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check(pins_out, 3'h6);
    axr(`PLH_CTRL_OFFSET, d, r);
    check(d[0], 1'b1);
    axw(`PLH_CTRL_OFFSET, 32'h0, r);
    check(r, `PLH_RESP_OKAY);
    repeat (3) @(posedge aclk);
    check(n_commit, 1);
    check(last_commit, 1'b0);
    i_ctl.pulse(1);
    settle(0);
    axw(`PLH_CTRL_OFFSET, 32'h1, r);
    settle(1);
    @(posedge aclk) sense_n_in <= 1'b1;
    i_ctl.pulse(2);
    settle(1);
    axr(`PLH_STATUS_OFFSET, d, r);
    check(d[0], 1'b0);
    @(posedge aclk) sense_n_in <= 1'b0;
    settle(2);
    for (int i = 0; i < 6; i++)
    begin
      ok = (i < 2) ? i[0] : $random(seed);
      i_ctl.ok_cfg = ok;
      i_ctl.dly_cfg = 1 + ($random(seed) & 15);
      if (i[0])
        i_ctl.launch_polled(1 + ($random(seed) & 1), oks, errs);
      else
        i_ctl.launch(1 + ($random(seed) & 1), oks, errs);
      check(oks, ok);
      check(errs, !ok);
    end
    i_ctl.dly_cfg = 30;
    fork
      i_ctl.launch(1, oks, errs);
      begin
        repeat (12) @(posedge aclk);
        i_ctl.pulse(2);
      end
    join
    settle(9);
    i_ctl.dly_cfg = 4;
    @(posedge aclk) port_io_supply <= 1'b0;
    repeat (3) @(posedge aclk);
    check(pins_oe, 3'h0);
    i_ctl.pulse(1);
    repeat (20) @(posedge aclk);
    check(n_start, 9);
    @(posedge aclk) port_io_supply <= 1'b1;
    settle(10);
    axw(`PLH_STATUS_OFFSET, 32'hFFFF_FFFF, r);
    check(r, `PLH_RESP_OKAY);
    axr(`PLH_STATUS_OFFSET, d, r);
    check(d & 32'h43, exp_status(1'b1, 1'b0, 1'b1));
    axr(8'h10, d, r);
    check(r, `PLH_RESP_SLVERR);
    check(d, `PLH_READ_ZERO);
    report_and_stop();
  end

  initial
  begin
    #300us;
    n_fail = n_fail + 1;
    report_and_stop();
  end
endmodule // plh_launch_port_tb

// file: plh_nv_store.sv
// non-volatile copy of the launch permission setting
`timescale 1ns/1ps
`include "plh_regs.svh"

module plh_nv_store (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic nv_saved_value,
  input  wire logic wr_en,
  input  wire logic wr_data,
  output logic      enable,
  output logic      commit_req,
  output logic      commit_data
);

  logic loaded_reg;
  logic enable_reg;
  logic commit_req_reg;
  logic commit_data_reg;

  // ========================================================================
  // load after reset release, so the setting survives power cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      loaded_reg <= 1'h0;
    else
      loaded_reg <= 1'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enable_reg <= `PLH_ENABLE_RESET;
    else if (wr_en)
      enable_reg <= wr_data;
    else if (!loaded_reg)
      enable_reg <= nv_saved_value;
  end

  // ========================================================================
  // every write is committed to the backing store
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      commit_req_reg  <= 1'h0;
      commit_data_reg <= 1'h0;
    end
    else
    begin
      commit_req_reg <= wr_en;
      if (wr_en)
        commit_data_reg <= wr_data;
    end
  end

  assign enable      = enable_reg;
  assign commit_req  = commit_req_reg;
  assign commit_data = commit_data_reg;

endmodule // plh_nv_store

// file: plh_pkg.sv
// types of the launch handshake block
package plh_pkg;

  // ========================================================================
  // axi4-lite carriers
  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } plh_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } plh_axi_rsp_type;

  // ========================================================================
  // port pins, active low as on the connector
  typedef struct packed {
    logic pass_n;
    logic fail_n;
    logic idle_n;
  } plh_pins_type;

  // ========================================================================
  // launch sequence
  typedef enum logic [2:0] {
    PLH_IDLE,
    PLH_CLEAR,
    PLH_BUSY,
    PLH_REPORT,
    PLH_RELEASE
  } plh_state_type;

endpackage

// file: plh_regs.svh
// register offsets, field positions and reset values of the launch handshake block
`ifndef PLH_REGS_SVH
`define PLH_REGS_SVH

// ==========================================================================
// register byte offsets
`define PLH_CTRL_OFFSET       8'h00
`define PLH_STATUS_OFFSET     8'h04
`define PLH_RESULT_OFFSET     8'h08
`define PLH_ADDR_W            8

// ==========================================================================
// control register fields
`define PLH_CTRL_ENABLE_BIT   0

// ==========================================================================
// status register fields
`define PLH_STAT_ACTIVE_BIT   0
`define PLH_STAT_BUSY_BIT     1
`define PLH_STAT_PASS_BIT     2
`define PLH_STAT_FAIL_BIT     3
`define PLH_STAT_PEND_BIT     4
`define PLH_STAT_SUPPLY_BIT   5
`define PLH_STAT_ENABLE_BIT   6

// ==========================================================================
// result register fields
`define PLH_RES_PASS_BIT      0
`define PLH_RES_FAIL_BIT      1

// ==========================================================================
// reset values and bus answers
`define PLH_ENABLE_RESET      1'h0
`define PLH_RESP_OKAY         2'h0
`define PLH_RESP_SLVERR       2'h2
`define PLH_READ_ZERO         32'h0000_0000

`endif
